/* design/tcu_pkg.sv */
// Package of constants and carrier types for the tick counter unit
package tcu_pkg;

    // Bus clock rate and the crossing delay of synchronised value writes
    localparam int unsigned CLK_MHZ   = 50;
    localparam int unsigned SYNC_NS   = 60;
    localparam logic [1:0]  SYNC_CYC  = 2'((SYNC_NS * CLK_MHZ + 999) / 1000);

    localparam int unsigned DATA_W    = 32;
    localparam int unsigned PRE_W     = 10;
    localparam int unsigned NFLAG     = 3;

    // Flag, event and DMA request bit positions
    localparam int unsigned FL_OVF    = 0;
    localparam int unsigned FL_CH0    = 1;
    localparam int unsigned FL_CH1    = 2;

    // Write selector codes
    localparam logic [2:0] SEL_CTRL    = 3'h0;
    localparam logic [2:0] SEL_DBG     = 3'h1;
    localparam logic [2:0] SEL_COUNT   = 3'h2;
    localparam logic [2:0] SEL_PER     = 3'h3;
    localparam logic [2:0] SEL_CC0     = 3'h4;
    localparam logic [2:0] SEL_CC1     = 3'h5;
    localparam logic [2:0] SEL_FLAGCLR = 3'h6;

    // Counter width masks and period reset value
    localparam logic [31:0] MASK_8    = 32'h0000_00ff;
    localparam logic [31:0] MASK_16   = 32'h0000_ffff;
    localparam logic [31:0] MASK_32   = 32'hffff_ffff;
    localparam logic [31:0] PER_RST   = 32'h0000_00ff;

    // Prescaler last-count values for divide by 1,2,4,8,16,64,256,1024
    localparam logic [9:0] PRE_D1     = 10'h000;
    localparam logic [9:0] PRE_D2     = 10'h001;
    localparam logic [9:0] PRE_D4     = 10'h003;
    localparam logic [9:0] PRE_D8     = 10'h007;
    localparam logic [9:0] PRE_D16    = 10'h00f;
    localparam logic [9:0] PRE_D64    = 10'h03f;
    localparam logic [9:0] PRE_D256   = 10'h0ff;
    localparam logic [9:0] PRE_D1024  = 10'h3ff;

    typedef enum logic [2:0] {
        TCU_M8  = 3'b001,
        TCU_M16 = 3'b010,
        TCU_M32 = 3'b100
    } tcu_mode_e;

    typedef enum logic [1:0] {
        TCU_NFRQ = 2'h0,
        TCU_MFRQ = 2'h1,
        TCU_NPWM = 2'h2,
        TCU_MPWM = 2'h3
    } tcu_wave_e;

    // Control word, packed from WR.data[18:0], first field at the top
    typedef struct packed {
        logic       enable;
        logic       soft_reset;
        logic       count_events;
        logic       dir_down;
        tcu_mode_e  mode;
        tcu_wave_e  wavegen;
        logic [2:0] presc;
        logic [1:0] capten;
        logic [1:0] inven;
        logic [2:0] inten;
    } tcu_cfg_s;

    localparam int unsigned CFG_W = $bits(tcu_cfg_s);

    typedef struct packed {
        logic        valid;
        logic [2:0]  sel;
        logic [31:0] data;
        logic        from_debugger;
    } tcu_wr_s;

    typedef struct packed {
        tcu_cfg_s    cfg;
        logic        dbg_run;
        logic [31:0] count;
        logic [31:0] per;
        logic [31:0] cc0;
        logic [31:0] cc1;
        logic [9:0]  pre_cnt;
        logic [2:0]  flags;
        logic [2:0]  dma;
        logic [2:0]  ev;
        logic [1:0]  tgl;
        logic [1:0]  wo;
        logic        irq;
        logic [1:0]  sync_cnt;
        logic [2:0]  pend_sel;
        logic [31:0] pend_data;
        logic        refused;
        logic        busy;
    } tcu_state_s;

    localparam tcu_cfg_s CFG_RST = '{
        enable: 1'b0, soft_reset: 1'b0, count_events: 1'b0,
        dir_down: 1'b0, mode: TCU_M16, wavegen: TCU_NFRQ,
        presc: 3'h0, capten: 2'h0, inven: 2'h0, inten: 3'h0};

    localparam tcu_state_s ST_RST = '{
        cfg: CFG_RST, per: PER_RST, default: '0};

endpackage : tcu_pkg

/* design/tcu_tick_counter_unit.sv */
// Tick counter unit: counter, prescaler, two compare/capture channels
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - The counter advances on incoming events or on counting clock ticks.
// - The counter runs as 8, 16 or 32 bits; 32 bits stands for a pair.
// - An input event captures the count into enabled channels.
// - Wave output line 0 gives frequency or single-slope PWM waveforms; line 1 gives PWM only.
// - Wrap and each channel match or capture raise flags and events.
// - The same conditions raise DMA requests and values stay readable for DMA.
// - Counting goes on in sleep while ticks arrive; the interrupt wakes.
// - Events leave on a pulse port for the event router, needing no wake-up.
// - One counting tick input serves both halves of a pair, never two sources.
// - Count, period and compare writes cross through a handshake.
// - A debug halt stops the counter unless debug run is set.
// - Control writes may be protected; value and flag writes are exempt.
// - Protection is lifted while the processor is halted in debug.
// - Writes from an external debugger are never blocked by protection.
// - Event counting bypasses the prescaler; counting ticks are then ignored.
// - Soft reset clears all but debug control and disables the unit.
module tcu_tick_counter_unit
    import tcu_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        NRST,
    input  wire logic        COUNT_TICK,
    input  wire logic        EV_IN,
    input  wire logic        DEBUG_HALT,
    input  wire logic        PROT_ON,
    input  wire logic        BUS_CLK_EN,
    input  wire tcu_wr_s     WR,
    input  wire logic [2:0]  DMA_ACK,
    output logic [1:0]       WAVE_OUT_LINES,
    output logic             IRQ,
    output logic [2:0]       EV_OUT,
    output logic [2:0]       DMA_REQ,
    output logic [31:0]      COUNT_VAL,
    output logic [31:0]      CC0_VAL,
    output logic [31:0]      CC1_VAL,
    output logic             SYNC_BUSY,
    output logic             WR_REFUSED
);

    tcu_state_s st_reg;
    tcu_state_s st_next;

    // Width mask of the selected counter resolution
    function automatic logic [31:0] mode_mask(input tcu_mode_e m);
        case (m)
            TCU_M8:  mode_mask = MASK_8;
            TCU_M32: mode_mask = MASK_32;
            default: mode_mask = MASK_16;
        endcase
    endfunction : mode_mask

    // Last prescaler count before a tick is passed on
    function automatic logic [9:0] presc_last(input logic [2:0] p);
        case (p)
            3'h1:    presc_last = PRE_D2;
            3'h2:    presc_last = PRE_D4;
            3'h3:    presc_last = PRE_D8;
            3'h4:    presc_last = PRE_D16;
            3'h5:    presc_last = PRE_D64;
            3'h6:    presc_last = PRE_D256;
            3'h7:    presc_last = PRE_D1024;
            default: presc_last = PRE_D1;
        endcase
    endfunction : presc_last

    // Next state of the whole unit
    always_comb
    begin
        logic [31:0] mask;
        logic [31:0] top;
        logic [2:0]  set;
        logic [2:0]  clr;
        logic [1:0]  raw;
        logic        run;
        logic        adv;
        logic        bus_ok;
        logic        locked;
        logic        is_sync;
        tcu_cfg_s    wcfg;
        mask    = mode_mask(st_reg.cfg.mode);
        top     = '0;
        set     = '0;
        clr     = '0;
        raw     = '0;
        run     = 1'b0;
        adv     = 1'b0;
        bus_ok  = 1'b0;
        locked  = 1'b0;
        is_sync = 1'b0;
        wcfg    = tcu_cfg_s'(WR.data[CFG_W-1:0]);
        st_next = st_reg;
        st_next.ev      = '0;
        st_next.refused = 1'b0;

        // Top: period in 8-bit mode, else full range; CC0 in match modes
        top = (st_reg.cfg.mode == TCU_M8) ? (st_reg.per & mask) : mask;
        if (st_reg.cfg.wavegen == TCU_MFRQ || st_reg.cfg.wavegen == TCU_MPWM)
            top = st_reg.cc0 & mask;

        // Sleep does not enter here at all, so counting goes on in sleep
        run = st_reg.cfg.enable && !(DEBUG_HALT && !st_reg.dbg_run);

        // Shared tick of the pair, divided unless events are counted
        if (run && COUNT_TICK && !st_reg.cfg.count_events)
        begin
            if (st_reg.pre_cnt >= presc_last(st_reg.cfg.presc))
            begin
                st_next.pre_cnt = '0;
                adv = 1'b1;
            end
            else
                st_next.pre_cnt = st_reg.pre_cnt + 10'h001;
        end
        if (run && st_reg.cfg.count_events && EV_IN)
            adv = 1'b1;

        // Count step with wrap at top or zero
        if (adv)
        begin
            if (!st_reg.cfg.dir_down)
            begin
                if (st_reg.count >= top)
                begin
                    st_next.count = '0;
                    set[FL_OVF] = 1'b1;
                end
                else
                    st_next.count = (st_reg.count + 32'h0000_0001) & mask;
            end
            else if (st_reg.count == '0)
            begin
                st_next.count = top;
                set[FL_OVF] = 1'b1;
            end
            else
                st_next.count = (st_reg.count - 32'h0000_0001) & mask;
            if (!st_reg.cfg.capten[0] && st_reg.count == (st_reg.cc0 & mask))
                set[FL_CH0] = 1'b1;
            if (!st_reg.cfg.capten[1] && st_reg.count == (st_reg.cc1 & mask))
                set[FL_CH1] = 1'b1;
        end

        // Timestamp capture on the input event
        if (run && EV_IN && st_reg.cfg.capten[0])
        begin
            st_next.cc0 = st_reg.count;
            set[FL_CH0] = 1'b1;
        end
        if (run && EV_IN && st_reg.cfg.capten[1])
        begin
            st_next.cc1 = st_reg.count;
            set[FL_CH1] = 1'b1;
        end

        // Waveforms; frequency modes toggle on wrap, PWM compares count
        case (st_reg.cfg.wavegen)
            TCU_NFRQ, TCU_MFRQ:
            begin
                if (set[FL_OVF])
                    st_next.tgl[0] = ~st_reg.tgl[0];
                raw = {1'b0, st_next.tgl[0]};
            end
            TCU_NPWM:
                raw = {st_next.count < (st_reg.cc1 & mask),
                       st_next.count < (st_reg.cc0 & mask)};
            TCU_MPWM:
            begin
                if (set[FL_OVF])
                    st_next.tgl[0] = ~st_reg.tgl[0];
                raw = {st_next.count < (st_reg.cc1 & mask),
                       st_next.tgl[0]};
            end
            default:
                raw = '0;
        endcase
        st_next.wo = raw ^ st_reg.cfg.inven;

        // A held value write lands after the crossing delay, over counting
        if (st_reg.sync_cnt != '0)
        begin
            st_next.sync_cnt = st_reg.sync_cnt - 2'h1;
            if (st_reg.sync_cnt == 2'h1)
            begin
                case (st_reg.pend_sel)
                    SEL_COUNT: st_next.count = st_reg.pend_data & mask;
                    SEL_PER:   st_next.per   = st_reg.pend_data;
                    SEL_CC0:   st_next.cc0   = st_reg.pend_data;
                    SEL_CC1:   st_next.cc1   = st_reg.pend_data;
                    default:   st_next.count = st_next.count;
                endcase
            end
        end

        // Write port; a gated bus clock makes it deaf, not the counter
        bus_ok  = BUS_CLK_EN && WR.valid;
        locked  = PROT_ON && !DEBUG_HALT && !WR.from_debugger
                  && (WR.sel == SEL_CTRL || WR.sel == SEL_DBG);
        is_sync = (WR.sel >= SEL_COUNT) && (WR.sel <= SEL_CC1);
        if (bus_ok)
        begin
            if (locked || (is_sync && st_reg.sync_cnt != '0))
                st_next.refused = 1'b1;
            else
            begin
                case (WR.sel)
                    SEL_CTRL:
                    begin
                        st_next.cfg = wcfg;
                        st_next.cfg.soft_reset = 1'b0;
                    end
                    SEL_DBG:
                        st_next.dbg_run = WR.data[0];
                    SEL_FLAGCLR:
                        clr = WR.data[NFLAG-1:0];
                    SEL_COUNT, SEL_PER, SEL_CC0, SEL_CC1:
                    begin
                        st_next.pend_sel  = WR.sel;
                        st_next.pend_data = WR.data;
                        st_next.sync_cnt  = SYNC_CYC;
                    end
                    default:
                        st_next.refused = 1'b1;
                endcase
            end
        end

        // A new event wins over a clear arriving in the same cycle
        st_next.flags = (st_reg.flags & ~clr) | set;
        st_next.dma   = (st_reg.dma & ~DMA_ACK) | set;
        st_next.ev    = set;
        st_next.irq   = |(st_next.flags & st_reg.cfg.inten);
        // Busy kept as its own flop so the port comes straight from one
        st_next.busy  = (st_next.sync_cnt != '0);

        // Soft reset keeps only the debug run setting
        if (bus_ok && !locked && WR.sel == SEL_CTRL && wcfg.soft_reset)
        begin
            st_next = ST_RST;
            st_next.dbg_run = st_reg.dbg_run;
        end
    end

    // State register
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // Outputs are state fields, so all come straight from flip-flops
    assign WAVE_OUT_LINES = st_reg.wo;
    assign IRQ            = st_reg.irq;
    assign EV_OUT         = st_reg.ev;
    assign DMA_REQ        = st_reg.dma;
    assign COUNT_VAL      = st_reg.count;
    assign CC0_VAL        = st_reg.cc0;
    assign CC1_VAL        = st_reg.cc1;
    assign SYNC_BUSY      = st_reg.busy;
    assign WR_REFUSED     = st_reg.refused;

endmodule : tcu_tick_counter_unit

`default_nettype wire

/* verif/tcu_chk_sva.sv */
// Port checker of the tick counter unit
`timescale 1ns/100ps
`default_nettype none
module tcu_chk
    import tcu_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        NRST,
    input wire logic        COUNT_TICK,
    input wire logic        EV_IN,
    input wire logic        DEBUG_HALT,
    input wire logic        PROT_ON,
    input wire logic        BUS_CLK_EN,
    input wire tcu_wr_s     WR,
    input wire logic [2:0]  EV_OUT,
    input wire logic [2:0]  DMA_REQ,
    input wire logic [31:0] COUNT_VAL,
    input wire logic        SYNC_BUSY,
    input wire logic        WR_REFUSED
);
    logic take;
    logic valw;
    logic ctlw;
    // A write counts only while the bus clock runs
    assign take = WR.valid && BUS_CLK_EN;
    assign valw = take && WR.sel inside {[SEL_COUNT:SEL_CC1]};
    assign ctlw = take && WR.sel <= SEL_DBG;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    property p_busy;
        valw && !SYNC_BUSY |=> SYNC_BUSY [*3] ##1 !SYNC_BUSY;
    endproperty
    a_busy: assert property (p_busy)
        else $error("sync busy not three cycles");
    property p_land;
        valw && !SYNC_BUSY && WR.sel == SEL_COUNT
            |-> ##4 COUNT_VAL == $past(WR.data, 4);
    endproperty
    a_land: assert property (p_land)
        else $error("count write did not land");
    property p_prot;
        ctlw && PROT_ON && !DEBUG_HALT && !WR.from_debugger |=> WR_REFUSED;
    endproperty
    a_prot: assert property (p_prot)
        else $error("protected write not refused");
    property p_free;
        ctlw && (DEBUG_HALT || WR.from_debugger) |=> !WR_REFUSED;
    endproperty
    a_free: assert property (p_free)
        else $error("debug write refused");
    property p_exempt;
        valw && !SYNC_BUSY |=> !WR_REFUSED;
    endproperty
    a_exempt: assert property (p_exempt)
        else $error("value write refused");
    property p_gate;
        !BUS_CLK_EN |=> !WR_REFUSED;
    endproperty
    a_gate: assert property (p_gate)
        else $error("gated write answered");
    property p_evdma;
        EV_OUT[FL_OVF] |-> DMA_REQ[FL_OVF];
    endproperty
    a_evdma: assert property (p_evdma)
        else $error("overflow event without dma request");
    property p_step;
        $changed(COUNT_VAL)
            |-> $past(COUNT_TICK || EV_IN || SYNC_BUSY || WR.valid);
    endproperty
    a_step: assert property (p_step)
        else $error("count moved without a tick");
    property p_why;
        WR_REFUSED |-> $past(take);
    endproperty
    a_why: assert property (p_why)
        else $error("refusal without a write");
endmodule : tcu_chk
bind tcu_tick_counter_unit tcu_chk u_chk (.CLOCK(CLOCK), .NRST(NRST),
    .COUNT_TICK(COUNT_TICK), .EV_IN(EV_IN), .DEBUG_HALT(DEBUG_HALT),
    .PROT_ON(PROT_ON), .BUS_CLK_EN(BUS_CLK_EN), .WR(WR), .EV_OUT(EV_OUT),
    .DMA_REQ(DMA_REQ), .COUNT_VAL(COUNT_VAL), .SYNC_BUSY(SYNC_BUSY),
    .WR_REFUSED(WR_REFUSED));
`default_nettype wire

/* verif/tcu_far_side.sv */
// Far side model: tick source, DMA controller and event router
`timescale 1ns/100ps
`default_nettype none
module tcu_far_side
    import tcu_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       tick_on,
    input  wire logic [1:0] delay,
    input  wire logic [2:0] dma_req,
    input  wire logic [2:0] ev_out,
    output logic            count_tick,
    output logic [2:0]      dma_ack,
    output logic [7:0]      n_ev
);
    logic [1:0] wait_cnt;
    logic       want;
    // Ack only after the chosen delay, so slow answers are exercised
    assign want = |dma_req && !(|dma_ack);
    always @(negedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            count_tick <= 1'b0;
            dma_ack <= 3'h0;
            wait_cnt <= 2'h0;
            n_ev <= 8'h00;
        end
        else
        begin
            count_tick <= tick_on;
            dma_ack <= 3'h0;
            if (|ev_out)
                n_ev <= n_ev + 8'h01;
            if (want)
                wait_cnt <= wait_cnt + 2'h1;
            if (want && wait_cnt >= delay)
            begin
                dma_ack <= dma_req;
                wait_cnt <= 2'h0;
            end
        end
    end
endmodule : tcu_far_side
`default_nettype wire

/* verif/tb_tcu_tick_counter_unit.sv */
// Self-checking bench of the tick counter unit
`timescale 1ns/100ps
`default_nettype none
module tb_tcu_tick_counter_unit
    import tcu_pkg::*;
;
    logic clock = 0, nrst = 0, ev_in = 0, halt = 0, prot = 0, bus_en = 1;
    logic tick_on = 0, count_tick, irq, busy, refused;
    logic [1:0] dly = 2'h1, wave;
    logic [2:0] dma_ack, ev_out, dma_req;
    logic [7:0] n_ev;
    logic [31:0] cnt, cc0, cc1;
    tcu_wr_s wr = '0;
    int n_errors = 0, checks = 0, cyc = 0;
    tcu_tick_counter_unit u_dut (.CLOCK(clock), .NRST(nrst),
        .COUNT_TICK(count_tick), .EV_IN(ev_in), .DEBUG_HALT(halt),
        .PROT_ON(prot), .BUS_CLK_EN(bus_en), .WR(wr), .DMA_ACK(dma_ack),
        .WAVE_OUT_LINES(wave), .IRQ(irq), .EV_OUT(ev_out),
        .DMA_REQ(dma_req), .COUNT_VAL(cnt), .CC0_VAL(cc0), .CC1_VAL(cc1),
        .SYNC_BUSY(busy), .WR_REFUSED(refused));
    tcu_far_side u_far (.clock(clock), .nrst(nrst), .tick_on(tick_on),
        .delay(dly), .dma_req(dma_req), .ev_out(ev_out),
        .count_tick(count_tick), .dma_ack(dma_ack), .n_ev(n_ev));
    always #10 clock = ~clock;
    task end_of_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // Hang guard, far above the some 130 cycles the run needs
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            end_of_test;
        end
    end
    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    // One-cycle write request, taken at the rising edge in between
    task automatic wd(input logic [2:0] s, input logic [31:0] d,
                      input logic dbg = 1'b0);
        @(negedge clock);
        wr = '{valid: 1'b1, sel: s, data: d, from_debugger: dbg};
        @(negedge clock);
        wr.valid = 1'b0;
    endtask : wd
    task automatic cy(input int n);
        repeat (n) @(negedge clock);
    endtask : cy
    task t_prot;
        prot = 1;
        wd(SEL_DBG, 32'h1);
        chk("refused", 1'b1, refused);
        wd(SEL_DBG, 32'h0, 1'b1);
        chk("dbgr", 1'b0, refused);
        halt = 1;
        wd(SEL_DBG, 32'h0);
        chk("halt", 1'b0, refused);
        halt = 0;
    endtask : t_prot
    task t_sync;
        wd(SEL_COUNT, 32'h5);
        chk("busy", 1'b1, busy);
        wd(SEL_CC1, 32'h9);
        chk("busyref", 1'b1, refused);
        cy(1);
        chk("busy0", 1'b0, busy);
        chk("count", 32'h5, cnt);
        chk("cc1", 32'h0, cc1);
        prot = 0;
    endtask : t_sync
    // Ticks run too: event counting must ignore them
    task t_event;
        tick_on <= 1'b1;
        wd(SEL_CTRL, 32'h51020);
        repeat (3)
        begin
            @(negedge clock) ev_in = 1;
            @(negedge clock) ev_in = 0;
        end
        cy(1);
        chk("evcount", 32'h8, cnt);
        chk("capture", 32'h7, cc0);
    endtask : t_event
    task t_count;
        logic [7:0] n0;
        tick_on <= 1'b0;
        dly = 2'h3;
        wd(SEL_CTRL, 32'h1001);
        wd(SEL_PER, 32'h3);
        cy(3);
        wd(SEL_COUNT, 32'h0);
        cy(3);
        wd(SEL_CTRL, 32'h41001);
        n0 = n_ev;
        tick_on <= 1'b1;
        for (int i = 0; i < 20 && ev_out[0] !== 1'b1; i++)
        begin
            @(negedge clock);
            chk("range", 1'b1, cnt <= 32'h3);
        end
        chk("ovf", 1'b1, ev_out[0]);
        chk("irq", 1'b1, irq);
        chk("dma", 1'b1, dma_req[0]);
        cy(2);
        chk("wave", 1'b1, wave[0]);
        chk("router", 1'b1, n_ev != n0);
        tick_on <= 1'b0;
        cy(8);
        chk("dmaack", 1'b0, dma_req[0]);
        wd(SEL_FLAGCLR, 32'h1);
        chk("irqclr", 1'b0, irq);
    endtask : t_count
    task automatic t_debug;
        logic [31:0] c;
        tick_on <= 1'b1;
        halt = 1;
        cy(2);
        c = cnt;
        cy(4);
        chk("halted", c, cnt);
        wd(SEL_DBG, 32'h1);
        cy(1);
        chk("dbgrun", 1'b1, cnt != c);
        halt = 0;
        wd(SEL_DBG, 32'h0);
    endtask : t_debug
    // Debug run set before soft reset must survive it
    task automatic t_srst;
        logic [31:0] c;
        wd(SEL_DBG, 32'h1);
        wd(SEL_CTRL, 32'h20000);
        cy(3);
        chk("srcount", 32'h0, cnt);
        chk("srirq", 1'b0, irq);
        wd(SEL_CTRL, 32'h42000);
        halt = 1;
        cy(3);
        chk("keeprun", 1'b1, cnt != 32'h0);
        halt = 0;
        bus_en = 0;
        c = cnt;
        wd(SEL_CC0, 32'h9);
        cy(4);
        chk("gbusy", 1'b0, busy);
        chk("gcc0", 32'h0, cc0);
        chk("gcount", 1'b1, cnt != c);
        bus_en = 1;
    endtask : t_srst
    // 8-bit single-slope PWM: line 1 high while the count is below 3
    task t_pwm;
        wd(SEL_CTRL, 32'h1000);
        wd(SEL_CC1, 32'h3);
        cy(3);
        wd(SEL_COUNT, 32'h0);
        cy(3);
        wd(SEL_CTRL, 32'h41800);
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clock);
            chk("pwmcnt", i + 1, cnt);
            chk("pwm1", i < 2, wave[1]);
            chk("pwm0", 1'b0, wave[0]);
        end
    endtask : t_pwm
    // Down count through divide by two; underflow reloads the top
    task t_down;
        wd(SEL_CTRL, 32'h1000);
        wd(SEL_COUNT, 32'h1);
        cy(3);
        wd(SEL_CTRL, 32'h49080);
        cy(3);
        chk("dncount", 32'h0, cnt);
        chk("dnwait", 1'b0, ev_out[0]);
        cy(1);
        chk("unf", 1'b1, ev_out[0]);
        chk("unftop", 32'hff, cnt);
    endtask : t_down
    initial
    begin
        cy(16);
        nrst = 1;
        chk("idle", 32'h0, {irq, busy, refused, wave, ev_out, dma_req});
        chk("count0", 32'h0, cnt);
        t_prot;
        t_sync;
        t_event;
        t_count;
        t_debug;
        t_srst;
        t_pwm;
        t_down;
        end_of_test;
    end
endmodule : tb_tcu_tick_counter_unit
`default_nettype wire
